// [design/result_pack.v]
// Packs a raw result value into a 24-bit result word with parity
`timescale 1ns/1ps
module result_pack #(
	parameter VALUE_WIDTH = 23
) (
	input wire [VALUE_WIDTH-1:0] value,
	output wire [23:0] word
);
	`include "tof_limits_defines.vh"

	// --------------------------------------------------------------
	// Zero-extend to 23 bits and add parity bit 23
	// --------------------------------------------------------------
	wire [22:0] body;
	assign body = {{(23-VALUE_WIDTH){1'b0}}, value};
	// Even parity over bits 22..0 by default
	assign word = {(^body) ^ `PARITY_ODD, body};
endmodule

// [design/tof_limits_defines.vh]
// Offsets, reset values, field positions and widths of the limit and result registers
`ifndef TOF_LIMITS_DEFINES_VH
`define TOF_LIMITS_DEFINES_VH

// --------------------------------------------------------------
// Register offsets
// --------------------------------------------------------------
`define OFS_OVF_LIMIT_HIGH 6'h06
`define OFS_OVF_LIMIT_LOW 6'h07
`define OFS_STOP_MASK_HIGH 6'h08
`define OFS_STOP_MASK_LOW 6'h09
`define OFS_FIRST_INTERVAL 6'h10
`define OFS_FIRST_TALLY 6'h11
`define OFS_SECOND_INTERVAL 6'h12
`define OFS_SECOND_TALLY 6'h13

// --------------------------------------------------------------
// Reset values
// --------------------------------------------------------------
`define RST_OVF_LIMIT_BYTE 8'hff
`define RST_STOP_MASK_BYTE 8'h00
`define RST_RESULT 24'h000000

// --------------------------------------------------------------
// Result field layout
// --------------------------------------------------------------
`define RES_PARITY_BIT 23
`define RES_VALUE_MSB 22
`define TALLY_MSB 15
`define TALLY_PAD_WIDTH 7
// Parity sense: 1 gives odd parity over bits 22..0 plus parity
`define PARITY_ODD 1'b0

`endif

// [design/tof_limits_regs.v]
// Clock counter limits, stop mask and first two result pairs
// Overview of operation
// - Overflow limit high byte, read/write, resets to ff.
// - Overflow limit low byte at 07h, read/write, resets to ff.
// - Stop mask high byte at 08h, read/write, resets to 00.
// - Stop mask low byte at 09h, read/write, resets to 00.
// - Time results are 24 bits, read-only, 23-bit value plus parity bit 23.
// - Tally results: count in 15..0, parity in 23, 22..16 read zero.
// - First time result at 10h, read-only, resets to zero.
// - First tally result at 11h, read-only, resets to zero.
// - Second time result at 12h, same layout, resets to zero.
// - Second tally result at 13h, same layout, resets to zero.
// - Counter reaching overflow limit flags overflow and stops measurement.
`timescale 1ns/1ps
module tof_limits_regs #(
	parameter TIME_WIDTH = 23,
	parameter COUNT_WIDTH = 16
) (
	input wire clock,
	input wire rst_b,
	// Host register port, same clock
	input wire [5:0] reg_addr,
	input wire reg_wr,
	input wire reg_rd,
	input wire [7:0] reg_wdata,
	output reg [23:0] reg_rdata,
	output reg reg_rvalid,
	// Measurement engine side
	input wire meas_start,
	input wire stop_pin,
	input wire [TIME_WIDTH-1:0] fine_time,
	input wire clock_overflow_clear,
	output reg meas_running,
	output reg clock_overflow_flag,
	output reg [COUNT_WIDTH-1:0] clock_count
);
	`include "tof_limits_defines.vh"

	// --------------------------------------------------------------
	// Stop pin synchroniser and edge detect
	// --------------------------------------------------------------
	reg stop_s1_r;
	reg stop_s2_r;
	reg stop_s3_r;
	wire stop_edge;
	// First stage feeds only the second
	always @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			stop_s1_r <= 1'b0;
			stop_s2_r <= 1'b0;
			stop_s3_r <= 1'b0;
		end else begin
			stop_s1_r <= stop_pin;
			stop_s2_r <= stop_s1_r;
			stop_s3_r <= stop_s2_r;
		end
	end
	assign stop_edge = stop_s2_r & ~stop_s3_r;

	// --------------------------------------------------------------
	// Writable limit and mask bytes
	// --------------------------------------------------------------
	reg [7:0] clock_overflow_limit_high_r;
	reg [7:0] clock_overflow_limit_low_r;
	reg [7:0] clock_stop_mask_high_r;
	reg [7:0] clock_stop_mask_low_r;
	always @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			clock_overflow_limit_high_r <= `RST_OVF_LIMIT_BYTE;
			clock_overflow_limit_low_r <= `RST_OVF_LIMIT_BYTE;
			clock_stop_mask_high_r <= `RST_STOP_MASK_BYTE;
			clock_stop_mask_low_r <= `RST_STOP_MASK_BYTE;
		end else if (reg_wr) begin
			// Result offsets and unmapped offsets ignore writes
			case (reg_addr)
			`OFS_OVF_LIMIT_HIGH: begin
				clock_overflow_limit_high_r <= reg_wdata;
			end
			`OFS_OVF_LIMIT_LOW: begin
				clock_overflow_limit_low_r <= reg_wdata;
			end
			`OFS_STOP_MASK_HIGH: begin
				clock_stop_mask_high_r <= reg_wdata;
			end
			`OFS_STOP_MASK_LOW: begin
				clock_stop_mask_low_r <= reg_wdata;
			end
			default: begin
			end
			endcase
		end
	end

	wire [15:0] ovf_limit;
	wire [15:0] stop_mask;
	assign ovf_limit = {clock_overflow_limit_high_r,
		clock_overflow_limit_low_r};
	assign stop_mask = {clock_stop_mask_high_r, clock_stop_mask_low_r};

	// --------------------------------------------------------------
	// Measurement sequencer, one-hot
	// --------------------------------------------------------------
	localparam [2:0] ST_IDLE = 3'b001;
	localparam [2:0] ST_WAIT1 = 3'b010;
	localparam [2:0] ST_WAIT2 = 3'b100;
	reg [2:0] state_r;
	reg [2:0] state_nxt;
	wire at_limit;
	wire stop_ok;
	wire [15:0] count16;
	assign count16 = clock_count[15:0];
	// Limit compare uses the full 16 bits of the programmed value
	assign at_limit = (count16 >= ovf_limit);
	// Stops before the mask count are dropped, not queued
	assign stop_ok = stop_edge & (count16 >= stop_mask);

	always @* begin
		state_nxt = state_r;
		case (state_r)
		ST_IDLE: begin
			if (meas_start) begin
				state_nxt = ST_WAIT1;
			end
		end
		ST_WAIT1: begin
			if (at_limit) begin
				state_nxt = ST_IDLE;
			end else if (stop_ok) begin
				state_nxt = ST_WAIT2;
			end
		end
		ST_WAIT2: begin
			if (at_limit || stop_ok) begin
				state_nxt = ST_IDLE;
			end
		end
		default: begin
			state_nxt = ST_IDLE;
		end
		endcase
	end

	// --------------------------------------------------------------
	// Counter, overflow flag and result capture
	// --------------------------------------------------------------
	wire [23:0] t_word;
	wire [23:0] c_word;
	reg [23:0] first_interval_result_r;
	reg [23:0] first_period_tally_r;
	reg [23:0] second_interval_result_r;
	reg [23:0] second_period_tally_r;
	wire running;
	wire capture;
	assign running = ~state_r[0];
	assign capture = stop_ok & ~at_limit & running;

	result_pack #(.VALUE_WIDTH(TIME_WIDTH)) u_time_pack (
		.value(fine_time),
		.word(t_word)
	);
	result_pack #(.VALUE_WIDTH(COUNT_WIDTH)) u_count_pack (
		.value(clock_count),
		.word(c_word)
	);

	always @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			state_r <= ST_IDLE;
			meas_running <= 1'b0;
			clock_count <= {COUNT_WIDTH{1'b0}};
			clock_overflow_flag <= 1'b0;
			first_interval_result_r <= `RST_RESULT;
			first_period_tally_r <= `RST_RESULT;
			second_interval_result_r <= `RST_RESULT;
			second_period_tally_r <= `RST_RESULT;
		end else begin
			state_r <= state_nxt;
			meas_running <= ~state_nxt[0];
			if (state_r[0] && meas_start) begin
				clock_count <= {COUNT_WIDTH{1'b0}};
			end else if (running && !at_limit) begin
				clock_count <= clock_count + 1'b1;
			end
			// Set wins over a clear in the same cycle
			if (running && at_limit) begin
				clock_overflow_flag <= 1'b1;
			end else if (clock_overflow_clear) begin
				clock_overflow_flag <= 1'b0;
			end
			// Value and parity land in the same edge
			if (capture && state_r[1]) begin
				first_interval_result_r <= t_word;
				first_period_tally_r <= c_word;
			end
			if (capture && state_r[2]) begin
				second_interval_result_r <= t_word;
				second_period_tally_r <= c_word;
			end
		end
	end

	// --------------------------------------------------------------
	// Read port, one cycle latency; unmapped offsets read zero
	// --------------------------------------------------------------
	always @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			reg_rdata <= 24'h000000;
			reg_rvalid <= 1'b0;
		end else begin
			reg_rvalid <= reg_rd;
			if (reg_rd) begin
				case (reg_addr)
				`OFS_OVF_LIMIT_HIGH: begin
					reg_rdata <= {16'h0000, clock_overflow_limit_high_r};
				end
				`OFS_OVF_LIMIT_LOW: begin
					reg_rdata <= {16'h0000, clock_overflow_limit_low_r};
				end
				`OFS_STOP_MASK_HIGH: begin
					reg_rdata <= {16'h0000, clock_stop_mask_high_r};
				end
				`OFS_STOP_MASK_LOW: begin
					reg_rdata <= {16'h0000, clock_stop_mask_low_r};
				end
				`OFS_FIRST_INTERVAL: begin
					reg_rdata <= first_interval_result_r;
				end
				`OFS_FIRST_TALLY: begin
					reg_rdata <= first_period_tally_r;
				end
				`OFS_SECOND_INTERVAL: begin
					reg_rdata <= second_interval_result_r;
				end
				`OFS_SECOND_TALLY: begin
					reg_rdata <= second_period_tally_r;
				end
				default: begin
					reg_rdata <= 24'h000000;
				end
				endcase
			end
		end
	end
endmodule

// [tb/tof_counter_limits_and_results_tb.sv]
// Self-checking bench for the limit and result registers
`timescale 1ns/1ps
module tof_counter_limits_and_results_tb;
`define CHK(n, e, s) begin checked++; if ((e) !== (s)) begin bad_count++; \
	$display("unexpected %s exp %h got %h", n, e, s); end end
	reg clock = 0, rst_b = 0, reg_wr = 0, reg_rd = 0, meas_start = 0;
	reg stop_pin = 0, clock_overflow_clear = 0;
	reg [5:0] reg_addr = 6'h00;
	reg [7:0] reg_wdata = 8'h00;
	reg [22:0] fine_time = 23'h000000;
	wire [23:0] reg_rdata;
	wire reg_rvalid, meas_running, clock_overflow_flag;
	wire [15:0] clock_count;
	integer bad_count = 0, checked = 0, i;
	reg [23:0] v;
	always #2.5 clock = ~clock;
	tof_limits_regs i_dut (.clock(clock), .rst_b(rst_b), .reg_addr(reg_addr),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
		.reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .meas_start(meas_start),
		.stop_pin(stop_pin), .fine_time(fine_time),
		.clock_overflow_clear(clock_overflow_clear),
		.meas_running(meas_running), .clock_overflow_flag(clock_overflow_flag),
		.clock_count(clock_count));
	// --------------------------------------------------------------
	// Register port tasks
	// --------------------------------------------------------------
	task wr(input [5:0] a, input [7:0] d); begin
		@(posedge clock);
		reg_wr <= 1'b1; reg_addr <= a; reg_wdata <= d;
		@(posedge clock);
		reg_wr <= 1'b0;
	end endtask
	task rd(input [5:0] a); begin
		@(posedge clock);
		reg_rd <= 1'b1; reg_addr <= a;
		@(posedge clock);
		reg_rd <= 1'b0;
		#1;
		`CHK("rvalid", 1'b1, reg_rvalid)
		v = reg_rdata;
	end endtask
	// Held long enough to pass the two-flop synchroniser
	task stp(input [22:0] ft); begin
		fine_time <= ft; stop_pin <= 1'b1;
		repeat (3) @(posedge clock);
		stop_pin <= 1'b0;
		repeat (3) @(posedge clock);
	end endtask
	task pulse_start; begin
		@(posedge clock); meas_start <= 1'b1;
		@(posedge clock); meas_start <= 1'b0;
	end endtask
	// Even parity over the value field
	function [23:0] tw(input [22:0] x); tw = {^x, x}; endfunction
	task conclude; begin
		if (bad_count == 0 && checked > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	end endtask
	// --------------------------------------------------------------
	// Tests
	// --------------------------------------------------------------
	initial begin
		repeat (5) @(posedge clock);
		rst_b <= 1'b1;
		for (i = 0; i < 8; i++) begin
			rd((i < 4) ? 6'h06 + i : 6'h0c + i);
			`CHK("reset", (i < 2) ? 24'hff : 24'h0, v)
		end
		rd(6'h3f); `CHK("unmapped", 24'h0, v)
		for (i = 0; i < 4; i++) begin
			wr(6'h06 + i, 8'ha5 + i); rd(6'h06 + i);
			`CHK("rw byte", {16'h0, 8'ha5 + i}, v)
			wr(6'h10 + i, 8'h5a); rd(6'h10 + i);
			`CHK("ro result", 24'h0, v)
		end
		wr(6'h06, 8'h00); wr(6'h07, 8'h40); wr(6'h08, 8'h00); wr(6'h09, 8'h10);
		// Early stop must be masked, the next two land in the result pairs
		pulse_start; stp(23'h155555);
		repeat (15) @(posedge clock);
		stp(23'h2a5a5a); stp(23'h000001);
		`CHK("running", 1'b0, meas_running)
		rd(6'h10); `CHK("first_interval_result", tw(23'h2a5a5a), v)
		rd(6'h12); `CHK("second_interval_result", tw(23'h000001), v)
		for (i = 0; i < 2; i++) begin
			rd(6'h11 + 2 * i);
			`CHK("tally pad", 8'h00, {v[23] ^ (^v[22:0]), v[22:16]})
			`CHK("tally range", 1'b1, v[15:0] >= 16'h10 && v[15:0] < 16'h40)
		end
		wr(6'h07, 8'h20); pulse_start;
		repeat (50) @(posedge clock);
		`CHK("ovf flag", 1'b1, clock_overflow_flag)
		`CHK("ovf stop", 1'b0, meas_running)
		`CHK("ovf count", 16'h0020, clock_count)
		clock_overflow_clear <= 1'b1;
		@(posedge clock); clock_overflow_clear <= 1'b0;
		@(posedge clock); #1;
		`CHK("ovf clear", 1'b0, clock_overflow_flag)
		conclude;
	end
	initial begin
		repeat (4000) @(posedge clock);
		bad_count++;
		conclude;
	end
endmodule

// [tb/tof_limits_regs_properties.sv]
// Port-level properties of the limit and result register block
`timescale 1ns/1ps
module tof_limits_regs_properties #(
	parameter TIME_WIDTH = 23,
	parameter COUNT_WIDTH = 16
) (
	input wire clock,
	input wire rst_b,
	input wire [5:0] reg_addr,
	input wire reg_wr,
	input wire reg_rd,
	input wire [7:0] reg_wdata,
	input wire [23:0] reg_rdata,
	input wire reg_rvalid,
	input wire meas_start,
	input wire stop_pin,
	input wire [TIME_WIDTH-1:0] fine_time,
	input wire clock_overflow_clear,
	input wire meas_running,
	input wire clock_overflow_flag,
	input wire [COUNT_WIDTH-1:0] clock_count
);
	default clocking @(posedge clock); endclocking
	default disable iff (!rst_b);
	// Reads of the four result words
	wire res_rd = reg_rd && reg_addr >= 6'h10 && reg_addr <= 6'h13;
	wire byte_rd = reg_rd && reg_addr >= 6'h06 && reg_addr <= 6'h09;
	wire tally_rd = reg_rd && (reg_addr == 6'h11 || reg_addr == 6'h13);
	AST_RD_ANSWER: assert property (reg_rd |=> reg_rvalid)
		else $error("read got no answer one cycle later");
	AST_BYTE_PAD: assert property (
		byte_rd |=> reg_rdata[23:8] == 16'h0000)
		else $error("byte register read with upper bits set");
	AST_TALLY_PAD: assert property (
		tally_rd |=> reg_rdata[22:16] == 7'h00)
		else $error("tally pad bits not zero");
	AST_PARITY: assert property (res_rd |=> !(^reg_rdata))
		else $error("result parity bit wrong");
	AST_OVF_STOP: assert property (
		$rose(clock_overflow_flag) |-> ##[0:1] !meas_running)
		else $error("measurement kept running after overflow");
	AST_OVF_HOLD: assert property (
		clock_overflow_flag && !clock_overflow_clear |=> clock_overflow_flag)
		else $error("overflow flag dropped without clear");
	AST_COUNT_RUN: assert property (
		meas_running && !clock_overflow_flag |=> !meas_running ||
		clock_overflow_flag || clock_count == $past(clock_count) + 1'b1)
		else $error("counter did not step while running");
	AST_START: assert property (
		meas_start && !meas_running |=> meas_running)
		else $error("start did not begin a measurement");
	// A new run must count from zero, never from a stale frozen value
	AST_COUNT_CLEAR: assert property (
		meas_start && !meas_running |=> clock_count == {COUNT_WIDTH{1'b0}})
		else $error("counter not cleared by start");
	// Read answer follows reg_rd one cycle later, never a stale level
	AST_RVALID_PULSE: assert property (
		!reg_rd |=> !reg_rvalid)
		else $error("read answer without a read");
endmodule

bind tof_limits_regs tof_limits_regs_properties #(.TIME_WIDTH(TIME_WIDTH),
	.COUNT_WIDTH(COUNT_WIDTH)) i_props (.clock(clock), .rst_b(rst_b),
	.reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
	.reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
	.meas_start(meas_start), .stop_pin(stop_pin), .fine_time(fine_time),
	.clock_overflow_clear(clock_overflow_clear),
	.meas_running(meas_running), .clock_overflow_flag(clock_overflow_flag),
	.clock_count(clock_count));
